// ==== hdl/dsl_pkg.sv ====
/*
  Constants shared by the dual converter serial load control block:
  serial word layout, register selects, channel addresses and codes.
  Assumes nothing of its surroundings.
*/
package dsl_pkg;
  // Serial word layout.
  localparam int          WORD_W      = 24;
  localparam int          CNT_W       = 5;
  localparam int          RW_BIT      = 23;
  localparam int          REG_MSB     = 21;
  localparam int          REG_LSB     = 19;
  localparam int          ADDR_MSB    = 18;
  localparam int          ADDR_LSB    = 16;
  localparam int          DATA_W      = 16;
  // Register selects.
  localparam logic [2:0]  REG_DAC     = 3'h0;
  localparam logic [2:0]  REG_CTRL    = 3'h1;
  localparam logic [2:0]  REG_GPIO    = 3'h2;
  localparam logic [2:0]  REG_INPUT   = 3'h3;
  // Channel addresses.
  localparam logic [2:0]  ADDR_A      = 3'h0;
  localparam logic [2:0]  ADDR_B      = 3'h1;
  localparam logic [2:0]  ADDR_ALL    = 3'h4;
  // Field positions in the control and port words.
  localparam int          CTRL_DAISY  = 0;
  localparam int          GPIO_DIR_LSB = 0;
  localparam int          GPIO_OUT_LSB = 2;
  localparam int          GPIO_IN_LSB  = 4;
  // Codes and values after reset.
  localparam logic [15:0] CLEAR_CODE  = 16'h0000;
  localparam logic [15:0] ZERO_VOLT   = 16'h8000;
  localparam logic [15:0] SIGN_FLIP   = 16'h8000;
  localparam logic [15:0] DAC_RESET   = 16'h0000;
  localparam logic [1:0]  GPIO_DIR_RESET = 2'h0;
  localparam logic [1:0]  GPIO_OUT_RESET = 2'h0;
  localparam logic        DAISY_RESET = 1'b0;
  // Synchroniser depth and host serial clock ceiling.
  localparam int          SYNC_STAGES = 2;
  localparam int          SCLK_MAX_MHZ = 30;
endpackage

// ==== hdl/dsl_sync.sv ====
/*
  Multi-bit two-stage level synchroniser into the system clock.
  Assumes each bit is an independent slow level.
*/
`timescale 1ns/1ps
module dsl_sync #(
  parameter int WIDTH = 1
) (
  // Clock.
  input  wire logic             mclk_i,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  import dsl_pkg::*;

  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge mclk_i) begin
    stage_one <= async_i;
    sync_o    <= stage_one;
  end
endmodule

// ==== hdl/dsl_top.sv ====
/*
  Digital control of a dual serial-input converter: serial shift
  register on the serial clock, frame decode, input and output code
  registers, load and clear control, port pins and monitor output.
  Assumes a serial master that frames whole 24-bit words and keeps
  the serial clock still while the block is reset; edges with the frame sync high are ignored.
*/
`timescale 1ns/1ps
module dsl_top (
  // System clock and reset.
  input  wire logic                       mclk_i,
  input  wire logic                       reset_i,
  // Serial link.
  input  wire logic                       sclk_i,
  input  wire logic                       frame_sync_n_i,
  input  wire logic                       serial_data_in_i,
  output logic                            serial_data_out_o,
  output logic                            serial_data_out_oe_o,
  // Load, clear, clamp and coding pins.
  input  wire logic                       load_outputs_n_i,
  input  wire logic                       clear_zero_n_i,
  input  wire logic                       output_clamp_in_i,
  input  wire logic                       coding_select_i,
  // Supply monitor.
  input  wire logic                       supply_ok_i,
  output logic                            monitor_reset_out_o,
  // Port pins, index 0 is gpio_pin_zero and index 1 is gpio_pin_one.
  input  wire logic [1:0]                 gpio_in_i,
  output logic      [1:0]                 gpio_out_o,
  output logic      [1:0]                 gpio_oe_o,
  // Offset-binary codes to the converter cores.
  output logic      [dsl_pkg::DATA_W-1:0] code_a_o,
  output logic      [dsl_pkg::DATA_W-1:0] code_b_o
);
  import dsl_pkg::*;

  // Link domain.
  logic [WORD_W-1:0] shreg;
  logic [CNT_W-1:0]  bit_cnt;
  logic [CNT_W-1:0]  rb_idx;
  // System domain.
  logic [7:0]        pins_s;
  logic              fs_s;
  logic              clr_s;
  logic              ldn_s;
  logic              clamp_s;
  logic              coding_s;
  logic              supply_s;
  logic [1:0]        gpin_s;
  logic              fs_q;
  logic              clr_q;
  logic              ldn_q;
  logic              frame_end;
  logic              clr_fall;
  logic              ldn_fall;
  logic              word_ok;
  logic              is_read;
  logic [2:0]        reg_sel;
  logic [2:0]        addr;
  logic [DATA_W-1:0] data;
  logic              hit_a;
  logic              hit_b;
  logic              wr_dac;
  logic [DATA_W-1:0] in_a;
  logic [DATA_W-1:0] in_b;
  logic [DATA_W-1:0] dac_a;
  logic [DATA_W-1:0] dac_b;
  logic              daisy;
  logic [1:0]        gp_dir;
  logic [1:0]        gp_out;
  logic              rb_mode;
  logic [WORD_W-1:0] rb_word;
  logic [DATA_W-1:0] rb_data;

  // Input shift register; the frame sync gates every edge. The serial clock
  // stands still while the block is reset, so the reset acts on its own here.
  always_ff @(negedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      shreg   <= '0;
      bit_cnt <= '0;
    end else if (!frame_sync_n_i) begin
      shreg   <= {shreg[WORD_W-2:0], serial_data_in_i};
      bit_cnt <= (bit_cnt == CNT_W'(WORD_W - 1)) ? '0 : bit_cnt + 1'b1;
    end
  end

  // Readback bit index, most significant bit first.
  assign rb_idx = (bit_cnt == '0) ? '0 : CNT_W'(WORD_W) - bit_cnt;

  // Serial output launched on the rising edge. The readback word and
  // its mode flag change only between frames, so they are static here.
  always_ff @(posedge sclk_i) begin
    if (!frame_sync_n_i) begin
      serial_data_out_o <= rb_mode ? rb_word[rb_idx] : shreg[WORD_W-1];
    end
  end

  dsl_sync #(
    .WIDTH (8)
  ) u_pin_sync (
    .mclk_i  (mclk_i),
    .async_i ({gpio_in_i, supply_ok_i, coding_select_i, output_clamp_in_i,
               load_outputs_n_i, clear_zero_n_i, frame_sync_n_i}),
    .sync_o  (pins_s)
  );

  assign {gpin_s, supply_s, coding_s, clamp_s, ldn_s, clr_s, fs_s} = pins_s;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fs_q  <= 1'b1;
      clr_q <= 1'b1;
      // A load pin tied low must not look like a falling edge after reset.
      ldn_q <= ldn_s;
    end else begin
      fs_q  <= fs_s;
      clr_q <= clr_s;
      ldn_q <= ldn_s;
    end
  end

  assign frame_end = fs_s & ~fs_q;
  assign clr_fall  = ~clr_s & clr_q;
  assign ldn_fall  = ~ldn_s & ldn_q;

  // The shift register is idle once the frame has ended; a partial word is dropped.
  assign word_ok = frame_end && (bit_cnt == '0);
  assign is_read = shreg[RW_BIT];
  assign reg_sel = shreg[REG_MSB:REG_LSB];
  assign addr    = shreg[ADDR_MSB:ADDR_LSB];
  assign data    = shreg[DATA_W-1:0];
  assign hit_a   = (addr == ADDR_A) || (addr == ADDR_ALL);
  assign hit_b   = (addr == ADDR_B) || (addr == ADDR_ALL);
  assign wr_dac  = word_ok && !is_read && (reg_sel == REG_DAC);

  // Input registers take every data write.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      in_a <= DAC_RESET;
      in_b <= DAC_RESET;
    end else if (wr_dac) begin
      if (hit_a) begin
        in_a <= data;
      end
      if (hit_b) begin
        in_b <= data;
      end
    end
  end

  // Output code registers: clear beats a load, a load edge beats a frame.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      dac_a <= DAC_RESET;
      dac_b <= DAC_RESET;
    end else if (clr_fall) begin
      dac_a <= CLEAR_CODE;
      dac_b <= CLEAR_CODE;
    end else if (ldn_fall) begin
      dac_a <= in_a;
      dac_b <= in_b;
    end else if (wr_dac && !ldn_s) begin
      if (hit_a) begin
        dac_a <= data;
      end
      if (hit_b) begin
        dac_b <= data;
      end
    end
  end

  // Control and port configuration writes.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      daisy  <= DAISY_RESET;
      gp_dir <= GPIO_DIR_RESET;
      gp_out <= GPIO_OUT_RESET;
    end else if (word_ok && !is_read) begin
      if (reg_sel == REG_CTRL) begin
        daisy <= data[CTRL_DAISY];
      end
      if (reg_sel == REG_GPIO) begin
        gp_dir <= data[GPIO_DIR_LSB+1:GPIO_DIR_LSB];
        gp_out <= data[GPIO_OUT_LSB+1:GPIO_OUT_LSB];
      end
    end
  end

  always_comb begin
    case (reg_sel)
      REG_DAC:   rb_data = addr == ADDR_B ? dac_b : dac_a;
      REG_INPUT: rb_data = addr == ADDR_B ? in_b : in_a;
      REG_CTRL:  rb_data = {{(DATA_W-1){1'b0}}, daisy};
      REG_GPIO:  rb_data = {{(DATA_W-6){1'b0}}, gpin_s, gp_out, gp_dir};
      default:   rb_data = '0;
    endcase
  end

  // A read command arms readback for the following frame only.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rb_mode <= 1'b0;
      rb_word <= '0;
    end else if (frame_end) begin
      rb_mode <= word_ok && is_read;
      rb_word <= {shreg[WORD_W-1:DATA_W], rb_data};
    end
  end

  // Pin outputs, all from flip-flops.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      serial_data_out_oe_o <= 1'b0;
      gpio_out_o           <= GPIO_OUT_RESET;
      gpio_oe_o            <= GPIO_DIR_RESET;
      monitor_reset_out_o  <= 1'b1;
    end else begin
      serial_data_out_oe_o <= daisy || rb_mode;
      gpio_out_o           <= gp_out;
      gpio_oe_o            <= gp_dir;
      monitor_reset_out_o  <= ~supply_s;
    end
  end

  // Codes to the cores; the clamp overrides without touching registers.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      code_a_o <= ZERO_VOLT;
      code_b_o <= ZERO_VOLT;
    end else if (!clamp_s) begin
      code_a_o <= ZERO_VOLT;
      code_b_o <= ZERO_VOLT;
    end else begin
      code_a_o <= coding_s ? dac_a : dac_a ^ SIGN_FLIP;
      code_b_o <= coding_s ? dac_b : dac_b ^ SIGN_FLIP;
    end
  end

  chk_shift_capture: assert property (
    @(negedge sclk_i) disable iff (reset_i)
    !frame_sync_n_i |=> shreg[0] == $past(serial_data_in_i) &&
                        shreg[WORD_W-1:1] == $past(shreg[WORD_W-2:0]))
    else $error("Serial bit not shifted in during frame.");

  chk_idle_hold: assert property (
    @(negedge sclk_i) disable iff (reset_i)
    frame_sync_n_i |=> $stable(shreg) && $stable(bit_cnt))
    else $error("Shift state moved outside a frame.");

  chk_chain_out: assert property (
    @(posedge sclk_i) disable iff (reset_i)
    !frame_sync_n_i && !rb_mode |=> serial_data_out_o == $past(shreg[WORD_W-1]))
    else $error("Serial output does not follow shift register.");

  chk_clear_zero: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    clr_fall |=> dac_a == CLEAR_CODE && dac_b == CLEAR_CODE)
    else $error("Clear edge did not zero both channels.");

  chk_direct_load: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    wr_dac && hit_a && !ldn_s && !clr_fall && !ldn_fall |=> dac_a == $past(data))
    else $error("Channel not updated at frame end with load low.");

  chk_deferred_hold: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    wr_dac && hit_b && ldn_s && !clr_fall
      |=> $stable(dac_b) && in_b == $past(data))
    else $error("Deferred write changed the output register.");

  chk_joint_load: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    ldn_fall && !clr_fall |=> dac_a == $past(in_a) && dac_b == $past(in_b))
    else $error("Load edge did not move both input registers.");

  chk_port_dir: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    word_ok && !is_read && reg_sel == REG_GPIO
      ##2 1'b1 |-> gpio_oe_o == $past(data[1:0], 2))
    else $error("Port direction not taken from command.");

  chk_clamp_zero: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    !clamp_s |=> code_a_o == ZERO_VOLT && code_b_o == ZERO_VOLT)
    else $error("Clamp did not force zero volt codes.");

  chk_clamp_keeps: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    !clamp_s && !clr_fall && !ldn_fall && !wr_dac |=> $stable(dac_a) && $stable(dac_b))
    else $error("Clamp altered stored codes.");

  chk_monitor_out: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    !$past(supply_ok_i, 3) && !$past(supply_ok_i, 2) |-> monitor_reset_out_o)
    else $error("Monitor output missed a supply fault.");

  chk_twos_coding: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    clamp_s && !coding_s |=> code_a_o == ($past(dac_a) ^ SIGN_FLIP))
    else $error("Twos complement code not converted.");
endmodule

// ==== tb/dsl_host.sv ====
/*
  Host serial master model that frames 24-bit words for the converter block.
  Assumes the bench calls one task at a time.
*/
`timescale 1ns/1ps
module dsl_host (
  // Serial pins.
  output logic      sclk_o,
  output logic      frame_sync_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  initial begin
    sclk_o = 1'b1;
    frame_sync_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // One frame at 12.5 MHz; data moves mid high phase, away from the fall.
  task automatic xfer(input logic [23:0] w, output logic [23:0] rd);
    frame_sync_n_o = 1'b0;
    sdi_o = w[23];
    #40;
    for (int i = 23; i >= 0; i--) begin
      sclk_o = 1'b0;
      #40;
      sclk_o = 1'b1;
      #20;
      rd = {rd[22:0], sdo_i};
      if (i > 0) sdi_o = w[i-1];
      #20;
    end
    frame_sync_n_o = 1'b1;
    sdi_o = ~sdi_o;
  endtask
  // Clock edges with the frame idle, for the stray edge case only.
  task automatic stray(input int n);
    repeat (n) begin
      sclk_o = 1'b0;
      #40;
      sclk_o = 1'b1;
      #40;
    end
  endtask
endmodule

// ==== tb/dsl_top_test.sv ====
/*
  Self-checking bench for the dual converter serial load control.
  Assumes the host model drives the serial pins.
*/
`timescale 1ns/1ps
module dsl_top_test;
  import dsl_pkg::*;
  logic              mclk, reset, load_n, clr_n, clamp_n, cs, sup_ok;
  logic       [1:0]  ext;
  logic       [23:0] rd, w;
  logic       [15:0] a, b;
  wire  logic        sclk, fs_n, sdi, serial_data_out, sdo_oe, mon;
  wire  logic [1:0]  g_out, g_oe;
  wire  logic [15:0] code_a, code_b;
  int                error_cnt = 0;
  int                cmp_count = 0;
  int                cyc = 0;

  dsl_host u_host (.sclk_o(sclk), .frame_sync_n_o(fs_n), .sdi_o(sdi), .sdo_i(serial_data_out));
  dsl_top u_dut (.mclk_i(mclk), .reset_i(reset), .sclk_i(sclk), .frame_sync_n_i(fs_n),
    .serial_data_in_i(sdi), .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(sdo_oe),
    .load_outputs_n_i(load_n), .clear_zero_n_i(clr_n), .output_clamp_in_i(clamp_n),
    .coding_select_i(cs), .supply_ok_i(sup_ok), .monitor_reset_out_o(mon),
    .gpio_in_i((g_oe & g_out) | (~g_oe & ext)), .gpio_out_o(g_out), .gpio_oe_o(g_oe),
    .code_a_o(code_a), .code_b_o(code_b));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      error_cnt = error_cnt + 1;
      close_out();
    end
  end

  function automatic logic [15:0] ex(input logic [15:0] d);
    return cs ? d : d ^ SIGN_FLIP;
  endfunction
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [2:0] r, input logic [2:0] ad, input logic [15:0] d);
    u_host.xfer({2'h0, r, ad, d}, rd);
    tick(10);
  endtask
  // The answer to a read comes out during the frame after it.
  task automatic rdb(input logic [2:0] r, input logic [2:0] ad);
    repeat (2) begin
      u_host.xfer({2'h2, r, ad, 16'h0000}, rd);
      tick(10);
    end
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    load_n = 1'b0;
    clr_n = 1'b1;
    clamp_n = 1'b1;
    cs = 1'b1;
    sup_ok = 1'b0;
    ext = 2'h3;
    void'($urandom(32'h3F15));
    repeat (3) @(posedge mclk);
    @(negedge mclk) reset = 1'b0;
    tick(6);
    chk("sdo_oe", 1'b0, sdo_oe);
    chk("gpio_oe", GPIO_DIR_RESET, g_oe);
    chk("gpio_out", GPIO_OUT_RESET, g_out);
    chk("rst_a", ex(DAC_RESET), code_a);
    u_host.xfer({2'h2, REG_CTRL, ADDR_A, 16'h0000}, rd);
    tick(10);
    done("reset");
    for (int k = 0; k < 2; k++) begin
      @(negedge mclk) cs = k[0];
      a = 16'($urandom);
      b = 16'($urandom);
      wr(REG_DAC, ADDR_A, a);
      wr(REG_DAC, ADDR_B, b);
      chk("code_a", ex(a), code_a);
      chk("code_b", ex(b), code_b);
    end
    wr(REG_DAC, ADDR_ALL, 16'h7FFF);
    chk("all_a", ex(16'h7FFF), code_a);
    chk("all_b", ex(16'h7FFF), code_b);
    done("load_low");
    @(negedge mclk) load_n = 1'b1;
    a = 16'($urandom);
    b = 16'($urandom);
    wr(REG_DAC, ADDR_A, a);
    wr(REG_DAC, ADDR_B, b);
    chk("held_a", 16'h7FFF, code_a);
    rdb(REG_INPUT, ADDR_A);
    chk("input_a", a, rd[15:0]);
    @(negedge mclk) load_n = 1'b0;
    for (int n = 0; n < 20 && code_a !== a; n++) @(negedge mclk);
    chk("both_a", a, code_a);
    chk("both_b", b, code_b);
    done("deferred");
    clr_n = 1'b0;
    tick(8);
    chk("clr_a", ex(CLEAR_CODE), code_a);
    chk("clr_b", ex(CLEAR_CODE), code_b);
    clr_n = 1'b1;
    a = 16'($urandom);
    wr(REG_DAC, ADDR_A, a);
    clamp_n = 1'b0;
    tick(8);
    chk("clamp_a", ZERO_VOLT, code_a);
    chk("clamp_b", ZERO_VOLT, code_b);
    clamp_n = 1'b1;
    tick(8);
    chk("kept_a", ex(a), code_a);
    chk("kept_b", ex(CLEAR_CODE), code_b);
    done("clear_clamp");
    u_host.stray(5);
    tick(8);
    chk("stray_a", ex(a), code_a);
    wr(REG_DAC, ADDR_B, 16'hFFFF);
    chk("after_b", ex(16'hFFFF), code_b);
    done("stray");
    wr(REG_CTRL, ADDR_A, 16'h0001);
    chk("daisy_oe", 1'b1, sdo_oe);
    w = {2'h0, REG_DAC, ADDR_A, 16'($urandom)};
    u_host.xfer(w, rd);
    tick(10);
    u_host.xfer({2'h0, REG_DAC, ADDR_B, 16'h1234}, rd);
    tick(10);
    chk("daisy", w[22:0], rd[23:1]);
    wr(REG_CTRL, ADDR_A, 16'h0000);
    chk("daisy_off", 1'b0, sdo_oe);
    done("daisy");
    ext = 2'($urandom);
    wr(REG_GPIO, ADDR_A, 16'h0009);
    chk("gpio_oe", 2'h1, g_oe);
    chk("gpio_out", 2'h2, g_out);
    rdb(REG_GPIO, ADDR_A);
    chk("gpio_rd", {ext[1], 1'b0, 4'h9}, rd[5:0]);
    done("gpio");
    for (int k = 0; k < 4; k++) begin
      sup_ok = k[0];
      tick(5);
      chk("mon", !sup_ok, mon);
    end
    done("monitor");
    close_out();
  end
endmodule
